// ==== hpp_host_port.sv ====
// Host processor port: 8-bit asynchronous-style host interface with two
// bus styles, address latch, open-drain completion and fault summaries.
// Assumes all host pins already synchronous to CLK; the board pulls up
// the completion line and the wire level is formed outside from the enables.
`timescale 1ns/100ps
`default_nettype none
module hpp_host_port
   import hpp_pkg::*;
#(
   parameter int FLAG_W = 8
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic STYLE_DSTROBE,
   input wire logic CS_N,
   input wire logic ALE,
   input wire logic [1:0] ADDR,
   input wire logic STRB_N,
   input wire logic RW_CTRL,
   input wire logic [7:0] DATA_IN,
   output logic [7:0] DATA_OUT,
   output logic DATA_OE,
   output logic TRANSFER_ACK_N_OUT,
   output logic TRANSFER_ACK_N_OE,
   input wire logic [FLAG_W-1:0] CLK_FAULT_EVT,
   input wire logic [FLAG_W-1:0] SYS_FAULT_EVT,
   output logic CLOCK_FAULT_OUT,
   output logic SYSTEM_FAULT_OUT,
   output logic [HPP_MCR_CTRL_W-1:0] MASTER_CTRL,
   output logic [15:0] IND_ADDR,
   output logic [7:0] IND_WDATA,
   output logic IND_WR,
   output logic IND_RD,
   input wire logic [7:0] IND_RDATA
);
   hpp_style_e style; // Decoded bus style
   logic acc_act; // An access is in progress
   logic acc_read; // Access direction is read
   logic acc_start; // First cycle of an access
   logic act_q; // Access seen last cycle
   logic rd_pend_q; // Read data due next cycle
   logic done_q; // Access completed
   logic ale_mode_q; // Host uses the address latch
   logic [1:0] addr_lat_q; // Latched register address
   logic [1:0] sel; // Effective register select
   logic [1:0] sel_q; // Select held for read data
   logic soft_rst; // Software reset pulse
   logic [HPP_MCR_CTRL_W-1:0] mcr_q; // Control part of master register
   logic [7:0] lar_q; // Lower indirect address
   logic [7:0] amr_q; // Mode and upper address
   logic [7:0] dout_q; // Read data register
   logic [7:0] dout_d; // Read data mux
   logic wr_strobe; // Write taken this cycle
   logic flag_space; // Data register routed to flags
   logic [FLAG_W-1:0] clk_clr; // Clear mask for clock flags
   logic [FLAG_W-1:0] sys_clr; // Clear mask for system flags
   logic [FLAG_W-1:0] clk_flags; // Clock fault flags
   logic [FLAG_W-1:0] sys_flags; // System fault flags
   logic clk_any; // Any clock flag set
   logic sys_any; // Any system flag set

   // Bus style decode
   assign style = STYLE_DSTROBE ? HPP_STYLE_DSTROBE : HPP_STYLE_SEPARATE;

   // Access qualification and direction
   always_comb begin
      acc_act = 1'b0;
      acc_read = 1'b0;
      if (!CS_N) begin // [R5]
         unique case (style)
            HPP_STYLE_SEPARATE: begin
               acc_act = !STRB_N || !RW_CTRL; // [R6] [R7]
               acc_read = !STRB_N; // [R6]
            end
            HPP_STYLE_DSTROBE: begin
               acc_act = !STRB_N; // [R6]
               acc_read = RW_CTRL; // [R7]
            end
            default: begin
               acc_act = 1'b0;
               acc_read = 1'b0;
            end
         endcase
      end
   end

   assign acc_start = acc_act && !act_q;

   // Access tracking
   always_ff @(posedge CLK) begin
      if (!RST_N) begin // [R1]
         act_q <= 1'b0;
      end else begin
         act_q <= acc_act;
      end
   end

   // Address latch: once a latch pulse is seen, the latched copy is used
   always_ff @(posedge CLK) begin
      if (!RST_N) begin // [R1]
         ale_mode_q <= 1'b0;
         addr_lat_q <= 2'h0;
      end else if (ALE) begin // [R4]
         ale_mode_q <= 1'b1;
         addr_lat_q <= ADDR;
      end
   end

   // Register select from pins or latch
   assign sel = (ale_mode_q && !ALE) ? addr_lat_q : ADDR; // [R2] [R4]

   // Write decode
   assign wr_strobe = acc_start && !acc_read;
   assign flag_space = (amr_q == HPP_MODE_FLAG_SPACE);
   assign soft_rst = wr_strobe && (sel == HPP_SEL_MASTER) && DATA_IN[HPP_MCR_SOFT_RESET_BIT]; // [R13]

   // Host registers; soft reset bit is a pulse and never stored
   always_ff @(posedge CLK) begin
      if (!RST_N || soft_rst) begin // [R1] [R12] [R13]
         mcr_q <= HPP_RESET_BYTE[HPP_MCR_CTRL_W-1:0];
         lar_q <= HPP_RESET_BYTE;
         amr_q <= HPP_RESET_BYTE;
      end else if (wr_strobe) begin
         unique case (sel) // [R11]
            HPP_SEL_MASTER: mcr_q <= DATA_IN[HPP_MCR_CTRL_W-1:0];
            HPP_SEL_LOWER: lar_q <= DATA_IN;
            HPP_SEL_MODE: amr_q <= DATA_IN;
            HPP_SEL_DATA: begin
               // Indirect data goes out through the strobe below
            end
         endcase
      end
   end

   // Indirect strobes toward the core
   always_ff @(posedge CLK) begin
      if (!RST_N) begin // [R1]
         IND_WR <= 1'b0;
         IND_RD <= 1'b0;
         IND_WDATA <= HPP_RESET_BYTE;
      end else begin
         IND_WR <= wr_strobe && (sel == HPP_SEL_DATA) && !flag_space;
         IND_RD <= acc_start && acc_read && (sel == HPP_SEL_DATA) && !flag_space;
         if (wr_strobe) begin
            IND_WDATA <= DATA_IN;
         end
      end
   end

   assign IND_ADDR = {amr_q, lar_q};
   assign MASTER_CTRL = mcr_q;

   // Write-one-to-clear masks for the flag space
   always_comb begin
      clk_clr = '0;
      sys_clr = '0;
      if (wr_strobe && (sel == HPP_SEL_DATA) && flag_space) begin
         if (lar_q == HPP_FLAG_IDX_CLOCK) begin
            clk_clr = DATA_IN[FLAG_W-1:0];
         end
         if (lar_q == HPP_FLAG_IDX_SYSTEM) begin
            sys_clr = DATA_IN[FLAG_W-1:0];
         end
      end
   end

   // Clock fault flag group
   hpp_fault_flags #(.WIDTH(FLAG_W)) u_clk_flags (
      .clk(CLK),
      .rst_n(RST_N),
      .soft_rst(soft_rst),
      .evt(CLK_FAULT_EVT),
      .clr(clk_clr),
      .flags(clk_flags),
      .any(clk_any)
   );

   // System fault flag group
   hpp_fault_flags #(.WIDTH(FLAG_W)) u_sys_flags (
      .clk(CLK),
      .rst_n(RST_N),
      .soft_rst(soft_rst),
      .evt(SYS_FAULT_EVT),
      .clr(sys_clr),
      .flags(sys_flags),
      .any(sys_any)
   );

   // Fault summaries from registered flags
   assign CLOCK_FAULT_OUT = clk_any; // [R9]
   assign SYSTEM_FAULT_OUT = clk_any || sys_any; // [R10]

   // Read data mux, used one cycle after the start of a read
   always_comb begin
      dout_d = HPP_RESET_BYTE;
      unique case (sel_q) // [R11]
         HPP_SEL_MASTER: begin
            dout_d[HPP_MCR_CTRL_W-1:0] = mcr_q;
            dout_d[HPP_MCR_CLK_FAULT_BIT] = clk_any;
            dout_d[HPP_MCR_SYS_FAULT_BIT] = sys_any;
         end
         HPP_SEL_LOWER: dout_d = HPP_RESET_BYTE; // Write only
         HPP_SEL_MODE: dout_d = HPP_RESET_BYTE; // Write only
         HPP_SEL_DATA: begin
            if (!flag_space) begin
               dout_d = IND_RDATA;
            end else if (lar_q == HPP_FLAG_IDX_CLOCK) begin
               dout_d[FLAG_W-1:0] = clk_flags;
            end else if (lar_q == HPP_FLAG_IDX_SYSTEM) begin
               dout_d[FLAG_W-1:0] = sys_flags;
            end
         end
      endcase
   end

   // Read pipeline and completion
   always_ff @(posedge CLK) begin
      if (!RST_N) begin // [R1] [R12]
         rd_pend_q <= 1'b0;
         sel_q <= HPP_SEL_MASTER;
         dout_q <= HPP_RESET_BYTE;
         done_q <= 1'b0;
      end else begin
         rd_pend_q <= acc_start && acc_read;
         if (acc_start) begin
            sel_q <= sel;
         end
         if (rd_pend_q) begin
            dout_q <= dout_d;
         end
         // Completion two cycles after start, held until the access ends
         if (!acc_act) begin
            done_q <= 1'b0;
         end else if (act_q) begin
            done_q <= 1'b1;
         end
      end
   end

   // Data bus drive only during a read
   assign DATA_OUT = dout_q;
   assign DATA_OE = acc_act && acc_read && done_q; // [R3]

   // Open-drain completion: separate style holds not-ready low until done,
   // data-strobe style pulls the acknowledge low once done
   assign TRANSFER_ACK_N_OUT = 1'b0;
   always_comb begin
      TRANSFER_ACK_N_OE = 1'b0;
      if (!CS_N && acc_act) begin // [R14]
         unique case (style)
            HPP_STYLE_SEPARATE: TRANSFER_ACK_N_OE = !done_q; // [R8]
            HPP_STYLE_DSTROBE: TRANSFER_ACK_N_OE = done_q; // [R8]
            default: TRANSFER_ACK_N_OE = 1'b0;
         endcase
      end
   end
endmodule : hpp_host_port
`default_nettype wire

// ==== hpp_pkg.sv ====
// Package for the host processor port: register selects, field positions,
// reset values and the indirect flag space.
// Assumes a single 20 MHz clock domain and a synchronous active-low reset.
// Summary of operation
// R1: Low master reset holds block in initial state
// R2: Two address bits select a host register
// R3: Eight-bit data bus, driven only during reads
// R4: Address latch enable captures address for multiplexed hosts
// R5: Strobes ignored unless chip select is low
// R6: Shared strobe: read strobe or data strobe
// R7: Second input: write strobe or direction select
// R8: Open-drain ready or low transfer acknowledge completes access
// R9: Clock fault output ORs clock flags only
// R10: System fault output ORs all flags
// R11: Four registers: control/status, lower, mode/upper, data
// R12: All host registers clear to zero at reset
// R13: Writing one to bit seven resets registers
// R14: Completion line released while chip select inactive
package hpp_pkg;
   // Register selects on the two address bits
   localparam logic [1:0] HPP_SEL_MASTER = 2'h0;
   localparam logic [1:0] HPP_SEL_LOWER = 2'h1;
   localparam logic [1:0] HPP_SEL_MODE = 2'h2;
   localparam logic [1:0] HPP_SEL_DATA = 2'h3;
   // Master control/status fields
   localparam int HPP_MCR_SOFT_RESET_BIT = 7;
   localparam int HPP_MCR_SYS_FAULT_BIT = 6;
   localparam int HPP_MCR_CLK_FAULT_BIT = 5;
   localparam int HPP_MCR_CTRL_W = 5;
   // Reset values of host registers
   localparam logic [7:0] HPP_RESET_BYTE = 8'h00;
   // Mode value that routes the data register to the fault flags
   localparam logic [7:0] HPP_MODE_FLAG_SPACE = 8'hff;
   localparam logic [7:0] HPP_FLAG_IDX_CLOCK = 8'h00;
   localparam logic [7:0] HPP_FLAG_IDX_SYSTEM = 8'h01;
   // Bus styles
   typedef enum logic [1:0] {
      HPP_STYLE_SEPARATE = 2'b01,
      HPP_STYLE_DSTROBE = 2'b10
   } hpp_style_e;
endpackage : hpp_pkg

// ==== hpp_fault_flags.sv ====
// Sticky fault flag register with write-one-to-clear.
// Assumes event inputs synchronous to CLK; set wins over clear.
`timescale 1ns/100ps
`default_nettype none
module hpp_fault_flags
   import hpp_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic soft_rst,
   input wire logic [WIDTH-1:0] evt,
   input wire logic [WIDTH-1:0] clr,
   output logic [WIDTH-1:0] flags,
   output logic any
);
   logic [WIDTH-1:0] flag_q; // Sticky flags

   // One sticky cell per flag bit
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_flag
         always_ff @(posedge clk) begin
            if (!rst_n || soft_rst) begin // [R1] [R12] [R13]
               flag_q[gi] <= 1'b0;
            end else if (evt[gi]) begin // Set beats clear
               flag_q[gi] <= 1'b1;
            end else if (clr[gi]) begin
               flag_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   assign flags = flag_q;
   assign any = |flag_q; // OR summary of this group
endmodule : hpp_fault_flags
`default_nettype wire

// ==== hpp_host_port_assertions.sv ====
// Checker for the host port: completion line, bus drive, fault summaries.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module hpp_host_port_assertions
   import hpp_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic STYLE_DSTROBE,
   input wire logic CS_N,
   input wire logic STRB_N,
   input wire logic RW_CTRL,
   input wire logic DATA_OE,
   input wire logic TRANSFER_ACK_N_OUT,
   input wire logic TRANSFER_ACK_N_OE,
   input wire logic CLOCK_FAULT_OUT,
   input wire logic SYSTEM_FAULT_OUT,
   input wire logic [HPP_MCR_CTRL_W-1:0] MASTER_CTRL,
   input wire logic IND_WR,
   input wire logic IND_RD
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Line released and bus undriven when not selected or not reading
   rel_ack_a: assert property (CS_N |-> !TRANSFER_ACK_N_OE)
      else $error("Completion line held while deselected");
   rd_only_a: assert property (DATA_OE |-> !CS_N && !STRB_N && RW_CTRL)
      else $error("Data bus driven outside a read");
   open_drain_a: assert property (TRANSFER_ACK_N_OE |-> !TRANSFER_ACK_N_OUT)
      else $error("Completion line driven high");
   fault_sum_a: assert property (CLOCK_FAULT_OUT |-> SYSTEM_FAULT_OUT)
      else $error("System summary misses a clock flag");
   // Reset clears registers whatever the other pins do
   reset_clr_a: assert property (disable iff (1'b0) !RST_N |=> !(|MASTER_CTRL) && !SYSTEM_FAULT_OUT)
      else $error("State not cleared by reset");
   ds_ack_a: assert property (STYLE_DSTROBE && !CS_N && $fell(STRB_N) |->
      !TRANSFER_ACK_N_OE [*2] ##1 (TRANSFER_ACK_N_OE && DATA_OE == RW_CTRL))
      else $error("Acknowledge timing wrong");
   sep_ready_a: assert property (!STYLE_DSTROBE && !CS_N && ($fell(STRB_N) || $fell(RW_CTRL)) |->
      TRANSFER_ACK_N_OE [*2] ##1 !TRANSFER_ACK_N_OE)
      else $error("Ready timing wrong");
   ind_pulse_a: assert property (IND_WR || IND_RD |=> !IND_WR && !IND_RD)
      else $error("Indirect strobe too long");
   ind_cs_a: assert property (IND_WR || IND_RD |-> $past(CS_N) == 1'b0)
      else $error("Indirect strobe without select");
   cover property (STYLE_DSTROBE && TRANSFER_ACK_N_OE && DATA_OE);
   cover property (!STYLE_DSTROBE && $fell(TRANSFER_ACK_N_OE));
   cover property (SYSTEM_FAULT_OUT && !CLOCK_FAULT_OUT);
endmodule : hpp_host_port_assertions
bind hpp_host_port hpp_host_port_assertions i_hpp_host_port_assertions (
   .CLK(CLK), .RST_N(RST_N), .STYLE_DSTROBE(STYLE_DSTROBE), .CS_N(CS_N), .STRB_N(STRB_N),
   .RW_CTRL(RW_CTRL), .DATA_OE(DATA_OE), .TRANSFER_ACK_N_OUT(TRANSFER_ACK_N_OUT),
   .TRANSFER_ACK_N_OE(TRANSFER_ACK_N_OE), .CLOCK_FAULT_OUT(CLOCK_FAULT_OUT),
   .SYSTEM_FAULT_OUT(SYSTEM_FAULT_OUT), .MASTER_CTRL(MASTER_CTRL), .IND_WR(IND_WR), .IND_RD(IND_RD)
);
`default_nettype wire

// ==== hpp_host_model.sv ====
// Host processor model: one access at a time in either bus style.
// Assumes the bench resolves the data bus and pulls the completion line up.
`timescale 1ns/100ps
`default_nettype none
module hpp_host_model (
   input wire logic clk,
   input wire logic style,
   input wire logic ack_line,
   input wire logic [7:0] bus,
   output logic cs_n = 1'b1,
   output logic ale = 1'b0,
   output logic [1:0] addr = 2'h0,
   output logic strb_n = 1'b1,
   output logic rw_ctrl = 1'b1,
   output logic [7:0] hd = 8'h00,
   output logic hoe = 1'b0,
   output logic [7:0] got = 8'h00,
   output logic got_v = 1'b0
);
   // Select level c, lat sends the address through the latch first
   task automatic acc(input logic c, input logic we, input logic lat, input logic [1:0] a, input logic [7:0] d);
      logic seen;
      seen = 1'b0;
      @(posedge clk);
      ale <= lat;
      addr <= a;
      if (lat) begin
         @(posedge clk);
         ale <= 1'b0;
         addr <= ~a;
      end
      cs_n <= c;
      strb_n <= style ? 1'b0 : we;
      rw_ctrl <= !we;
      hd <= d;
      hoe <= we;
      // Hold everything until the completion line says done or 20 cycles pass
      for (int n = 0; n < 20; n++) begin
         @(posedge clk);
         seen = seen | !ack_line;
         if (style ? !ack_line : seen && ack_line) break;
      end
      got <= bus;
      got_v <= !we;
      cs_n <= 1'b1;
      strb_n <= 1'b1;
      rw_ctrl <= 1'b1;
      hoe <= 1'b0;
      @(posedge clk);
      got_v <= 1'b0;
   endtask : acc
endmodule : hpp_host_model
`default_nettype wire

// ==== host_processor_port_tb_top.sv ====
// Testbench: host model drives the port, a monitor checks read and
// indirect write data against queued notes. Assumes flag space at mode 0xff.
`timescale 1ns/100ps
`default_nettype none
module host_processor_port_tb_top
   import hpp_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic style = 1'b0;
   logic [7:0] clk_evt = 8'h00;
   logic [7:0] sys_evt = 8'h00;
   logic [7:0] ind_rdata = 8'h00;
   logic [7:0] data_out, ind_wdata, m_d, m_got, r1, r2;
   logic data_oe, ack_oe, ack_out, cs_n, ale, strb_n, rw_ctrl, m_oe, m_got_v, clock_fault, system_fault, ind_wr, ind_rd;
   logic [4:0] master_ctrl;
   logic [15:0] ind_addr;
   logic [1:0] addr;
   logic [7:0] exp_q[$];
   int bad_count = 0;
   int n_checks = 0;
   int n_rd = 0; // Indirect read pulses seen
   int seed = 32'hf926;
   // Pull-ups on the completion line and the data bus
   wire logic ack_line = ack_oe ? ack_out : 1'b1;
   wire logic [7:0] bus = data_oe ? data_out : (m_oe ? m_d : 8'hff);
   hpp_host_port i_hpp_host_port (
      .CLK(clk), .RST_N(rst_n), .STYLE_DSTROBE(style), .CS_N(cs_n), .ALE(ale), .ADDR(addr),
      .STRB_N(strb_n), .RW_CTRL(rw_ctrl), .DATA_IN(bus), .DATA_OUT(data_out), .DATA_OE(data_oe),
      .TRANSFER_ACK_N_OUT(ack_out), .TRANSFER_ACK_N_OE(ack_oe), .CLK_FAULT_EVT(clk_evt),
      .SYS_FAULT_EVT(sys_evt), .CLOCK_FAULT_OUT(clock_fault), .SYSTEM_FAULT_OUT(system_fault),
      .MASTER_CTRL(master_ctrl), .IND_ADDR(ind_addr), .IND_WDATA(ind_wdata), .IND_WR(ind_wr),
      .IND_RD(ind_rd), .IND_RDATA(ind_rdata)
   );
   hpp_host_model i_hpp_host_model (
      .clk(clk), .style(style), .ack_line(ack_line), .bus(bus), .cs_n(cs_n), .ale(ale), .addr(addr),
      .strb_n(strb_n), .rw_ctrl(rw_ctrl), .hd(m_d), .hoe(m_oe), .got(m_got), .got_v(m_got_v)
   );
   always #25 clk = ~clk;
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      i_hpp_host_model.acc(1'b0, 1'b1, 1'b0, a, d);
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_hpp_host_model.acc(1'b0, 1'b0, 1'b0, a, 8'h00);
   endtask : rd
   task automatic pulse(input logic [7:0] c, input logic [7:0] s);
      clk_evt <= c;
      sys_evt <= s;
      @(posedge clk);
      clk_evt <= 8'h00;
      sys_evt <= 8'h00;
      repeat (2) @(posedge clk);
   endtask : pulse
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   // Oldest note is taken whenever a read ends or an indirect write pulses
   always @(posedge clk) begin
      if (m_got_v || ind_wr) begin
         chk("result", {16'h0, m_got_v ? m_got : ind_wdata}, {16'h0, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx});
      end
      if (ind_rd) begin
         n_rd++; // Counted against the data register reads outside the flag space, one per style
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int s = 0; s < 2; s++) begin
         style <= s[0];
         r1 = 8'($random(seed));
         r2 = 8'($random(seed)) & 8'h7f;
         wr(HPP_SEL_MASTER, 8'h15);
         chk("ctrl", {19'h0, master_ctrl}, 24'h15);
         rd(HPP_SEL_MASTER, 8'h15);
         wr(HPP_SEL_LOWER, r1);
         wr(HPP_SEL_MODE, r2);
         chk("ind addr", {8'h0, ind_addr}, {8'h0, r2, r1});
         rd(HPP_SEL_LOWER, 8'h00);
         exp_q.push_back(r1 ^ 8'h5a);
         wr(HPP_SEL_DATA, r1 ^ 8'h5a);
         ind_rdata <= r2;
         rd(HPP_SEL_DATA, r2);
         // Strobes with select high: no effect, bus floats high
         i_hpp_host_model.acc(1'b1, 1'b1, 1'b0, HPP_SEL_DATA, r1);
         exp_q.push_back(8'hff);
         i_hpp_host_model.acc(1'b1, 1'b0, 1'b0, HPP_SEL_MASTER, 8'h00);
         wr(HPP_SEL_MODE, HPP_MODE_FLAG_SPACE);
         wr(HPP_SEL_LOWER, HPP_FLAG_IDX_CLOCK);
         pulse(r1 | 8'h01, 8'h00);
         chk("faults", {22'h0, clock_fault, system_fault}, 24'h3);
         rd(HPP_SEL_DATA, r1 | 8'h01);
         wr(HPP_SEL_DATA, 8'hff);
         wr(HPP_SEL_LOWER, HPP_FLAG_IDX_SYSTEM);
         pulse(8'h00, 8'h80);
         chk("faults", {22'h0, clock_fault, system_fault}, 24'h1);
         wr(HPP_SEL_MASTER, 8'h80);
         chk("soft rst", {2'h0, master_ctrl, ind_addr, system_fault}, 24'h0);
         rd(HPP_SEL_MASTER, 8'h00);
         chk("ind reads", 24'(n_rd), 24'(s + 1));
         $display("style %0d tests done", s);
      end
      wr(HPP_SEL_MASTER, 8'h0a);
      pulse(8'h00, 8'h04);
      chk("faults", {22'h0, clock_fault, system_fault}, 24'h1);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk("reset", {1'h0, clock_fault, system_fault, master_ctrl, ind_addr}, 24'h0);
      rst_n <= 1'b1;
      i_hpp_host_model.acc(1'b0, 1'b1, 1'b1, HPP_SEL_LOWER, 8'h3c);
      chk("latched", {8'h0, ind_addr}, 24'h3c);
      $display("reset and latch tests done");
      print_verdict();
   end
   initial begin
      repeat (6000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
endmodule : host_processor_port_tb_top
`default_nettype wire
